// file: hdl/dtd_pkg.sv
// Shared constants and state type of the duplex threshold and detector control block.
package dtd_pkg;
	// Register byte addresses on the AXI4-Lite bus.
	localparam logic [7:0] THR_GAIN_ADDR = 8'h00;
	localparam logic [7:0] DET_DIS_ADDR = 8'h04;
	localparam logic [7:0] STATUS_ADDR = 8'h08;
	// Register-select codes held in bits 3..0; writable fields sit in bits 15..4.
	localparam logic [3:0] THR_GAIN_SEL = 4'h8;
	localparam logic [3:0] DET_DIS_SEL = 4'ha;
	localparam logic [15:0] FIELD_MASK = 16'hfff0;
	localparam logic [15:0] THR_GAIN_RESET = 16'h0000;
	localparam logic [15:0] DET_DIS_RESET = 16'h0000;
	// Field positions of the threshold and gain register.
	localparam int A_ERLE_POS = 14;
	localparam int A_NOISE_POS = 12;
	localparam int N_ERLE_POS = 10;
	localparam int N_NOISE_POS = 8;
	localparam int RX_GAIN_POS = 6;
	localparam int TX_GAIN_POS = 4;
	// Field positions of the detector and canceller disable register.
	localparam int HOWL_OFF_POS = 15;
	localparam int TONE_OFF_POS = 14;
	localparam int APC_OFF_POS = 13;
	localparam int NPC_OFF_POS = 12;
	localparam int A_PRE_OFF_POS = 11;
	localparam int N_PRE_OFF_POS = 10;
	localparam int A_CANC_OFF_POS = 9;
	localparam int N_CANC_OFF_POS = 8;
	localparam int A_SDT_POS = 6;
	localparam int N_SDT_POS = 4;
	// Status register bit positions.
	localparam int ST_FULL_POS = 0;
	localparam int ST_A_ADMIT_POS = 1;
	localparam int ST_N_ADMIT_POS = 2;
	localparam int ST_N_AUTO_POS = 3;
	// Threshold codes and their levels in dB.
	localparam logic [1:0] CODE_00 = 2'h0;
	localparam logic [1:0] CODE_01 = 2'h1;
	localparam logic [1:0] CODE_10 = 2'h2;
	localparam logic [7:0] ERLE_24_DB = 8'h18;
	localparam logic [7:0] ERLE_18_DB = 8'h12;
	localparam logic [7:0] ERLE_30_DB = 8'h1e;
	localparam logic signed [7:0] NOISE_M42_DB = 8'hd6;
	localparam logic signed [7:0] NOISE_M54_DB = 8'hca;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [15:0] w_data;
		logic [1:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] thr_gain;
		logic [15:0] det_dis;
		logic full_duplex;
		logic a_admit;
		logic n_admit;
		logic aec_clear;
		logic nec_clear;
		logic aec_freeze;
		logic force_receive;
		logic aec_in_path;
		logic nec_in_path;
		logic nec_auto_off;
	} dtd_state_t;
endpackage

// file: hdl/dtd_ctrl.sv
// Duplex threshold, gain and detector control registers with the decisions they steer.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module dtd_ctrl (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// AXI4-Lite write address and data.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Measurements from the echo-cancelling engine.
	input wire logic [7:0] aec_erle_db,
	input wire logic [7:0] nec_erle_db,
	input wire logic signed [7:0] near_noise_db,
	input wire logic signed [7:0] far_noise_db,
	input wire logic aec_asym_ok,
	input wire logic nec_asym_ok,
	input wire logic net_path_present,
	// Detector events, one per cycle of detection.
	input wire logic howl_event,
	input wire logic tone_event,
	input wire logic acoustic_path_change,
	input wire logic network_path_change,
	// Controls to the engine and analog front end.
	output logic full_duplex,
	output logic aec_coef_clear,
	output logic nec_coef_clear,
	output logic aec_coef_freeze,
	output logic force_receive,
	output logic aec_in_path,
	output logic nec_in_path,
	output logic [1:0] rx_analog_gain,
	output logic [1:0] tx_analog_gain,
	output logic acoustic_preemph_off,
	output logic network_preemph_off,
	output logic [1:0] acoustic_sidetone_level,
	output logic [1:0] network_sidetone_level
);
	dtd_pkg::dtd_state_t s;
	dtd_pkg::dtd_state_t next_s;

	// Reserved ERLE code is treated as the strictest level so a bad write never eases admission.
	function automatic logic [7:0] erle_level(input logic [1:0] code);
		unique case (code)
			dtd_pkg::CODE_00: erle_level = dtd_pkg::ERLE_24_DB;
			dtd_pkg::CODE_01: erle_level = dtd_pkg::ERLE_18_DB;
			default: erle_level = dtd_pkg::ERLE_30_DB;
		endcase
	endfunction

	// A noise code of zero, or the reserved code, leaves ERLE as the only criterion.
	function automatic logic admit(input logic [7:0] erle, input logic [1:0] erle_code,
			input logic signed [7:0] noise, input logic [1:0] noise_code, input logic asym);
		logic erle_ok;
		erle_ok = erle > erle_level(erle_code);
		unique case (noise_code)
			dtd_pkg::CODE_01: admit = (noise > dtd_pkg::NOISE_M42_DB) ? erle_ok : asym;
			dtd_pkg::CODE_10: admit = (noise > dtd_pkg::NOISE_M54_DB) ? erle_ok : asym;
			default: admit = erle_ok;
		endcase
	endfunction

	logic [1:0] a_erle_code;
	logic [1:0] a_noise_code;
	logic [1:0] n_erle_code;
	logic [1:0] n_noise_code;
	logic howl_off;
	logic tone_off;
	logic apc_off;
	logic npc_off;
	logic a_canc_off;
	logic n_canc_off;
	logic do_write;
	logic [15:0] wmask;
	logic [15:0] wval;
	logic howl_hit;
	logic tone_hit;

	assign a_erle_code = s.thr_gain[dtd_pkg::A_ERLE_POS +: 2];
	assign a_noise_code = s.thr_gain[dtd_pkg::A_NOISE_POS +: 2];
	assign n_erle_code = s.thr_gain[dtd_pkg::N_ERLE_POS +: 2];
	assign n_noise_code = s.thr_gain[dtd_pkg::N_NOISE_POS +: 2];
	assign howl_off = s.det_dis[dtd_pkg::HOWL_OFF_POS];
	assign tone_off = s.det_dis[dtd_pkg::TONE_OFF_POS];
	assign apc_off = s.det_dis[dtd_pkg::APC_OFF_POS];
	assign npc_off = s.det_dis[dtd_pkg::NPC_OFF_POS];
	assign a_canc_off = s.det_dis[dtd_pkg::A_CANC_OFF_POS];
	assign n_canc_off = s.det_dis[dtd_pkg::N_CANC_OFF_POS];
	assign do_write = s.aw_have && s.w_have && !s.bvalid;
	assign wmask = {{8{s.w_strb[1]}}, {8{s.w_strb[0]}}} & dtd_pkg::FIELD_MASK;
	assign howl_hit = howl_event && !howl_off;
	assign tone_hit = tone_event && !tone_off;

	always_comb begin
		next_s = s;
		wval = 16'h0000;
		// Address and data channels are taken independently, in either order.
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_have = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_have = 1'b1;
			next_s.w_data = s_axi_wdata[15:0];
			next_s.w_strb = s_axi_wstrb[1:0];
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (do_write) begin
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = dtd_pkg::RESP_OKAY;
			unique case (s.aw_addr)
				dtd_pkg::THR_GAIN_ADDR: begin
					wval = (s.thr_gain & ~wmask) | (s.w_data & wmask);
					next_s.thr_gain = wval;
				end
				dtd_pkg::DET_DIS_ADDR: begin
					wval = (s.det_dis & ~wmask) | (s.w_data & wmask);
					next_s.det_dis = wval;
				end
				dtd_pkg::STATUS_ADDR: begin
					next_s.bresp = dtd_pkg::RESP_OKAY;
				end
				default: begin
					next_s.bresp = dtd_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_s.awready = !next_s.aw_have;
		next_s.wready = !next_s.w_have;
		// One read at a time; arready drops while the answer waits.
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = dtd_pkg::RESP_OKAY;
			next_s.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				dtd_pkg::THR_GAIN_ADDR: next_s.rdata[15:0] = {s.thr_gain[15:4], dtd_pkg::THR_GAIN_SEL};
				dtd_pkg::DET_DIS_ADDR: next_s.rdata[15:0] = {s.det_dis[15:4], dtd_pkg::DET_DIS_SEL};
				dtd_pkg::STATUS_ADDR: begin
					next_s.rdata[dtd_pkg::ST_FULL_POS] = s.full_duplex;
					next_s.rdata[dtd_pkg::ST_A_ADMIT_POS] = s.a_admit;
					next_s.rdata[dtd_pkg::ST_N_ADMIT_POS] = s.n_admit;
					next_s.rdata[dtd_pkg::ST_N_AUTO_POS] = s.nec_auto_off;
				end
				default: next_s.rresp = dtd_pkg::RESP_SLVERR;
			endcase
		end
		next_s.arready = !next_s.rvalid;
		// Network canceller drops out when the noise threshold is set and no path is seen.
		next_s.nec_auto_off = (n_noise_code != dtd_pkg::CODE_00) && !net_path_present;
		next_s.aec_in_path = !a_canc_off;
		next_s.nec_in_path = !n_canc_off && !next_s.nec_auto_off;
		// A canceller outside the path counts as admitting, so it never blocks full duplex.
		next_s.a_admit = a_canc_off ||
			admit(aec_erle_db, a_erle_code, near_noise_db, a_noise_code, aec_asym_ok);
		next_s.n_admit = !next_s.nec_in_path ||
			admit(nec_erle_db, n_erle_code, far_noise_db, n_noise_code, nec_asym_ok);
		next_s.full_duplex = next_s.a_admit && next_s.n_admit && !howl_hit;
		next_s.aec_clear = howl_hit || (tone_hit && !s.full_duplex) ||
			(acoustic_path_change && !apc_off);
		next_s.nec_clear = howl_hit || (network_path_change && !npc_off);
		next_s.force_receive = tone_hit && !s.full_duplex;
		// Freezing only while the tone lasts keeps training going as soon as it ends.
		next_s.aec_freeze = tone_hit && s.full_duplex;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s <= '0;
			s.thr_gain <= dtd_pkg::THR_GAIN_RESET;
			s.det_dis <= dtd_pkg::DET_DIS_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = s.rdata;
	assign full_duplex = s.full_duplex;
	assign aec_coef_clear = s.aec_clear;
	assign nec_coef_clear = s.nec_clear;
	assign aec_coef_freeze = s.aec_freeze;
	assign force_receive = s.force_receive;
	assign aec_in_path = s.aec_in_path;
	assign nec_in_path = s.nec_in_path;
	assign rx_analog_gain = s.thr_gain[dtd_pkg::RX_GAIN_POS +: 2];
	assign tx_analog_gain = s.thr_gain[dtd_pkg::TX_GAIN_POS +: 2];
	assign acoustic_preemph_off = s.det_dis[dtd_pkg::A_PRE_OFF_POS];
	assign network_preemph_off = s.det_dis[dtd_pkg::N_PRE_OFF_POS];
	// The engine adds a linear coupling path whenever a level is non-zero.
	assign acoustic_sidetone_level = s.det_dis[dtd_pkg::A_SDT_POS +: 2];
	assign network_sidetone_level = s.det_dis[dtd_pkg::N_SDT_POS +: 2];

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	howl_clears_both_a: assert property (howl_event && !howl_off |=> aec_coef_clear && nec_coef_clear && !full_duplex)
		else $error("howl event did not clear both cancellers");
	howl_ignored_a: assert property (howl_event && howl_off && !(network_path_change && !npc_off) |=> !nec_coef_clear)
		else $error("disabled howl detector cleared network canceller");
	tone_half_a: assert property (tone_event && !tone_off && !full_duplex |=> aec_coef_clear && force_receive)
		else $error("tone in half duplex did not force receive");
	tone_full_a: assert property (tone_event && !tone_off && full_duplex && !howl_hit
			&& !(acoustic_path_change && !apc_off) |=> aec_coef_freeze && !aec_coef_clear && !force_receive)
		else $error("tone in full duplex did not only freeze");
	apc_clear_a: assert property (acoustic_path_change && !apc_off |=> aec_coef_clear)
		else $error("acoustic path change did not clear");
	npc_clear_a: assert property (network_path_change && !npc_off |=> nec_coef_clear)
		else $error("network path change did not clear");
	nec_auto_a: assert property (n_noise_code != dtd_pkg::CODE_00 && !net_path_present |=> !nec_in_path)
		else $error("network canceller kept without coupling path");
	aec_removed_a: assert property (a_canc_off |=> !aec_in_path)
		else $error("disabled acoustic canceller left in path");
	erle_sole_a: assert property (!a_canc_off && a_noise_code == dtd_pkg::CODE_00 && a_erle_code == dtd_pkg::CODE_00
			&& aec_erle_db <= dtd_pkg::ERLE_24_DB |=> !full_duplex)
		else $error("full duplex admitted below acoustic ERLE threshold");
	read_sel_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == dtd_pkg::DET_DIS_ADDR
			|=> s_axi_rvalid && s_axi_rdata[3:0] == dtd_pkg::DET_DIS_SEL)
		else $error("select code missing on read");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");

	// Canceller removal and the automatic network drop-out.
	nec_removed_a: assert property (n_canc_off
			|=> !nec_in_path)
		else $error("disabled network canceller left in path");
	aec_restored_a: assert property (!a_canc_off
			|=> aec_in_path)
		else $error("enabled acoustic canceller missing from path");
	nec_kept_a: assert property (!n_canc_off && (n_noise_code == dtd_pkg::CODE_00
			|| net_path_present) |=> nec_in_path)
		else $error("network canceller dropped without cause");
	both_off_admit_a: assert property (a_canc_off && n_canc_off && !howl_hit
			|=> full_duplex)
		else $error("disabled cancellers still blocked full duplex");

	// A detector that is switched off must leave its canceller alone, and the acoustic freeze must end with the tone.
	tone_ignored_a: assert property (tone_event && tone_off
			|=> !force_receive && !aec_coef_freeze)
		else $error("disabled tone detector still acted");
	apc_ignored_a: assert property (acoustic_path_change && apc_off && !howl_hit
			&& !(tone_hit && !full_duplex) |=> !aec_coef_clear)
		else $error("disabled acoustic path detector cleared coefficients");
	npc_ignored_a: assert property (network_path_change && npc_off && !howl_hit
			|=> !nec_coef_clear)
		else $error("disabled network path detector cleared coefficients");
	howl_aec_kept_a: assert property (howl_event && howl_off && !tone_hit
			&& !(acoustic_path_change && !apc_off) |=> !aec_coef_clear)
		else $error("disabled howl detector cleared acoustic canceller");
	freeze_ends_a: assert property (!tone_event
			|=> !aec_coef_freeze)
		else $error("acoustic freeze outlived the tone");

	// Admission thresholds of both cancellers.
	acoustic_admit_a: assert property (!a_canc_off && a_noise_code == dtd_pkg::CODE_00
			&& a_erle_code == dtd_pkg::CODE_00 && aec_erle_db > dtd_pkg::ERLE_24_DB |=> s.a_admit)
		else $error("acoustic ERLE above threshold not admitted");
	erle_low_a: assert property (!a_canc_off && a_noise_code == dtd_pkg::CODE_00
			&& a_erle_code == dtd_pkg::CODE_01 && aec_erle_db <= dtd_pkg::ERLE_18_DB |=> !full_duplex)
		else $error("full duplex admitted below the 18 dB acoustic threshold");
	erle_high_a: assert property (!a_canc_off && a_noise_code == dtd_pkg::CODE_00
			&& a_erle_code == dtd_pkg::CODE_10 && aec_erle_db <= dtd_pkg::ERLE_30_DB |=> !full_duplex)
		else $error("full duplex admitted below the 30 dB acoustic threshold");
	net_erle_sole_a: assert property (!n_canc_off && n_noise_code == dtd_pkg::CODE_00
			&& n_erle_code == dtd_pkg::CODE_00 && nec_erle_db <= dtd_pkg::ERLE_24_DB |=> !full_duplex)
		else $error("full duplex admitted below network ERLE threshold");
	noisy_erle_a: assert property (!a_canc_off && a_noise_code == dtd_pkg::CODE_01
			&& near_noise_db > dtd_pkg::NOISE_M42_DB && a_erle_code == dtd_pkg::CODE_00
			&& aec_erle_db <= dtd_pkg::ERLE_24_DB |=> !full_duplex)
		else $error("noisy near end admitted without enough ERLE");
	asym_admit_a: assert property (!a_canc_off && a_noise_code == dtd_pkg::CODE_01
			&& near_noise_db <= dtd_pkg::NOISE_M42_DB && aec_asym_ok |=> s.a_admit)
		else $error("quiet near end not admitted by the estimate");
	asym_refuse_a: assert property (!a_canc_off && a_noise_code == dtd_pkg::CODE_01
			&& near_noise_db <= dtd_pkg::NOISE_M42_DB && !aec_asym_ok |=> !full_duplex)
		else $error("quiet near end admitted against the estimate");

	// Register bus handshakes.
	read_gain_sel_a: assert property (s_axi_arvalid && s_axi_arready
			&& s_axi_araddr == dtd_pkg::THR_GAIN_ADDR
			|=> s_axi_rvalid && s_axi_rdata[3:0] == dtd_pkg::THR_GAIN_SEL)
		else $error("select code missing on gain register read");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
			|=> s_axi_rvalid)
		else $error("read answer missing after address taken");
	aw_refused_a: assert property (s_axi_awvalid && s_axi_awready
			|=> !s_axi_awready)
		else $error("second write address accepted while one is held");
	w_refused_a: assert property (s_axi_wvalid && s_axi_wready
			|=> !s_axi_wready)
		else $error("second write data accepted while one is held");
	ar_refused_a: assert property (s_axi_rvalid
			|-> !s_axi_arready)
		else $error("read address accepted while an answer waits");
	write_answer_a: assert property (s.aw_have && s.w_have && !s_axi_bvalid
			|=> s_axi_bvalid)
		else $error("write answer missing after address and data held");
endmodule

// file: test/tb_top.sv
// Self-checking testbench of the duplex threshold and detector control block.
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, aec_erle_db = 8'h00, nec_erle_db = 8'h00;
	logic signed [7:0] near_noise_db = 8'h00, far_noise_db = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf, ev = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, aec_asym_ok = 1'b0, nec_asym_ok = 1'b0, net_path_present = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, full_duplex;
	logic aec_coef_clear, nec_coef_clear, aec_coef_freeze, force_receive, aec_in_path, nec_in_path;
	logic acoustic_preemph_off, network_preemph_off;
	logic [1:0] s_axi_bresp, s_axi_rresp, rx_analog_gain, tx_analog_gain;
	logic [1:0] acoustic_sidetone_level, network_sidetone_level;
	logic [7:0] thr [3] = '{8'h18, 8'h12, 8'h1e};
	int miscompares = 0;
	int num_checks = 0;
	// Engine controls and register fields gathered into two words, so one compare covers each group.
	wire [31:0] ctl = {25'h0, full_duplex, aec_coef_clear, nec_coef_clear, aec_coef_freeze, force_receive,
		aec_in_path, nec_in_path};
	wire [31:0] fld = {22'h0, acoustic_preemph_off, network_preemph_off, rx_analog_gain, tx_analog_gain,
		acoustic_sidetone_level, network_sidetone_level};

	dtd_ctrl dtd_ctrl_inst (
		.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.aec_erle_db, .nec_erle_db, .near_noise_db, .far_noise_db, .aec_asym_ok, .nec_asym_ok,
		.net_path_present, .howl_event(ev[3]), .tone_event(ev[2]), .acoustic_path_change(ev[1]),
		.network_path_change(ev[0]), .full_duplex, .aec_coef_clear, .nec_coef_clear, .aec_coef_freeze,
		.force_receive, .aec_in_path, .nec_in_path, .rx_analog_gain, .tx_analog_gain,
		.acoustic_preemph_off, .network_preemph_off, .acoustic_sidetone_level, .network_sidetone_level
	);

	always #5 core_clk = ~core_clk;

	task chk(input logic [31:0] s, input logic [31:0] e, input string m);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, m, s, e);
		end
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Address and data are offered together; each is released at its own handshake.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge core_clk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
	endtask

	// Read data is only meaningful with an OKAY answer, so it is compared only then.
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
		if (er == dtd_pkg::RESP_OKAY)
			chk(s_axi_rdata, e, "rdata");
	endtask

	// Outputs are read as they stand just before an edge, so every input change stays on an edge.
	task settle;
		repeat (4) @(posedge core_clk);
	endtask

	// One-cycle event, then the cycle of response and the cycle after it.
	task ev_pulse(input logic [3:0] v, input logic [31:0] e, input logic [31:0] b);
		@(posedge core_clk);
		ev <= v;
		@(posedge core_clk);
		ev <= 4'h0;
		@(posedge core_clk);
		chk(ctl, e, "event response");
		@(posedge core_clk);
		chk(ctl, b, "after event");
	endtask

	task t_regs;
		logic [31:0] d;
		logic [1:0] c;
		rd(dtd_pkg::THR_GAIN_ADDR, 32'h8, dtd_pkg::RESP_OKAY);
		rd(dtd_pkg::DET_DIS_ADDR, 32'ha, dtd_pkg::RESP_OKAY);
		chk(ctl, 32'h03, "reset ctl");
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			d = {24'h0, c, ~c, 4'h0};
			wr(dtd_pkg::THR_GAIN_ADDR, d, dtd_pkg::RESP_OKAY);
			wr(dtd_pkg::DET_DIS_ADDR, d | 32'h5, dtd_pkg::RESP_OKAY);
			rd(dtd_pkg::DET_DIS_ADDR, d | 32'ha, dtd_pkg::RESP_OKAY);
			chk(fld, {22'h0, 2'b00, c, ~c, c, ~c}, "fields");
		end
		wr(dtd_pkg::THR_GAIN_ADDR, 32'hfa5a_aaa7, dtd_pkg::RESP_OKAY);
		wr(dtd_pkg::STATUS_ADDR, 32'h0, dtd_pkg::RESP_OKAY);
		wr(8'h0c, 32'h0, dtd_pkg::RESP_SLVERR);
		rd(dtd_pkg::THR_GAIN_ADDR, 32'haaa8, dtd_pkg::RESP_OKAY);
		rd(8'h0c, 32'h0, dtd_pkg::RESP_SLVERR);
		// Each strobe lane reaches only its own byte of the writable fields.
		s_axi_wstrb <= 4'h1;
		wr(dtd_pkg::DET_DIS_ADDR, 32'hffff, dtd_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'h2;
		wr(dtd_pkg::DET_DIS_ADDR, 32'h0300, dtd_pkg::RESP_OKAY);
		rd(dtd_pkg::DET_DIS_ADDR, 32'h03fa, dtd_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		wr(dtd_pkg::DET_DIS_ADDR, 32'h0, dtd_pkg::RESP_OKAY);
	endtask

	task t_admit;
		for (int i = 0; i < 3; i++) begin
			wr(dtd_pkg::THR_GAIN_ADDR, {16'h0, i[1:0], 2'b00, i[1:0], 10'h0}, dtd_pkg::RESP_OKAY);
			aec_erle_db <= thr[i];
			nec_erle_db <= thr[i] + 8'h01;
			settle;
			chk(ctl, 32'h03, "acoustic at threshold");
			aec_erle_db <= thr[i] + 8'h01;
			nec_erle_db <= thr[i];
			settle;
			chk(ctl, 32'h03, "network at threshold");
			nec_erle_db <= thr[i] + 8'h01;
			settle;
			chk(ctl, 32'h43, "both above");
		end
	endtask

	task t_noise;
		wr(dtd_pkg::THR_GAIN_ADDR, 32'h1200, dtd_pkg::RESP_OKAY);
		aec_erle_db <= 8'h00;
		nec_erle_db <= 8'h00;
		near_noise_db <= 8'hce;
		far_noise_db <= 8'hc4;
		aec_asym_ok <= 1'b1;
		nec_asym_ok <= 1'b1;
		settle;
		chk(ctl, 32'h43, "quiet uses estimate");
		aec_asym_ok <= 1'b0;
		settle;
		chk(ctl, 32'h03, "estimate refuses");
		rd(dtd_pkg::STATUS_ADDR, 32'h4, dtd_pkg::RESP_OKAY);
		aec_asym_ok <= 1'b1;
		near_noise_db <= 8'hd8;
		settle;
		chk(ctl, 32'h03, "noisy uses erle");
		aec_erle_db <= 8'h19;
		far_noise_db <= 8'hce;
		settle;
		chk(ctl, 32'h03, "far noisy uses erle");
		net_path_present <= 1'b0;
		settle;
		chk(ctl, 32'h42, "network auto off");
		rd(dtd_pkg::STATUS_ADDR, 32'hf, dtd_pkg::RESP_OKAY);
		wr(dtd_pkg::THR_GAIN_ADDR, 32'h1000, dtd_pkg::RESP_OKAY);
		settle;
		chk(ctl, 32'h03, "zero code keeps network");
		wr(dtd_pkg::THR_GAIN_ADDR, 32'h0, dtd_pkg::RESP_OKAY);
		aec_erle_db <= 8'h00;
		nec_erle_db <= 8'h19;
		near_noise_db <= 8'hce;
		settle;
		chk(ctl, 32'h03, "zero code erle only");
	endtask

	task t_events;
		aec_erle_db <= 8'h19;
		settle;
		chk(ctl, 32'h43, "full duplex");
		ev_pulse(4'h4, 32'h4b, 32'h43);
		ev_pulse(4'h8, 32'h33, 32'h43);
		aec_erle_db <= 8'h00;
		settle;
		ev_pulse(4'h4, 32'h27, 32'h03);
		ev_pulse(4'h2, 32'h23, 32'h03);
		ev_pulse(4'h1, 32'h13, 32'h03);
		wr(dtd_pkg::DET_DIS_ADDR, 32'hf000, dtd_pkg::RESP_OKAY);
		for (int i = 0; i < 4; i++)
			ev_pulse(4'h1 << i, 32'h03, 32'h03);
		wr(dtd_pkg::DET_DIS_ADDR, 32'h0f50, dtd_pkg::RESP_OKAY);
		settle;
		chk(ctl, 32'h40, "cancellers off");
		chk(fld, 32'h305, "filters and sidetone");
		rd(dtd_pkg::DET_DIS_ADDR, 32'h0f5a, dtd_pkg::RESP_OKAY);
	endtask

	// A second reset in mid-run must bring the readies, the engine controls, the register fields and both registers back to their reset values.
	task t_reset;
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk({29'h0, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0, "readies in reset");
		chk(ctl, 32'h0, "ctl in reset");
		chk(fld, 32'h0, "fields in reset");
		rst <= 1'b0;
		rd(dtd_pkg::THR_GAIN_ADDR, 32'h8, dtd_pkg::RESP_OKAY);
		rd(dtd_pkg::DET_DIS_ADDR, 32'ha, dtd_pkg::RESP_OKAY);
		chk(ctl, 32'h03, "ctl after reset");
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		t_regs;
		t_admit;
		t_noise;
		t_events;
		t_reset;
		final_report;
	end

	// The sequence needs well under 2000 cycles; this limit only catches a hung handshake.
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		final_report;
	end
endmodule
